// *** hw/tmc_pkg.sv ***
// Purpose: shared constants and types for the thermal monitor configuration bank
// Assumes: one 32-bit word per register, byte offsets 0x00, 0x04 and 0x08 (index times four)
// Notes:   register addresses, bit positions, reset values and timing constants live here; fan drive levels are coded in the design
package tmc_pkg;

    // register indices and byte addresses
    localparam logic [7:0]  MON_CTRL_IDX  = 8'h00;
    localparam logic [7:0]  MEAS_CTRL_IDX = 8'h01;
    localparam logic [7:0]  STATUS_IDX    = 8'h02;
    localparam logic [11:0] MON_CTRL_ADDR  = 12'h000;
    localparam logic [11:0] MEAS_CTRL_ADDR = 12'h004;
    localparam logic [11:0] STATUS_ADDR    = 12'h008;

    // reset values
    localparam logic [7:0] MON_CTRL_RST  = 8'h01;
    localparam logic [7:0] MEAS_CTRL_RST = 8'h00;

    // monitor_control bit positions
    localparam int MC_RUN      = 0;
    localparam int MC_LOCK     = 1;
    localparam int MC_READY    = 2;
    localparam int MC_FULL     = 3;
    localparam int MC_SPIN_DIS = 4;
    localparam int MC_TO_DIS   = 5;
    localparam int MC_SUPPLY5  = 6;
    localparam int MC_OFFBIN   = 7;

    // measurement_control bit positions
    localparam int MS_THERM10K = 0;
    localparam int MS_DIODE_CURRENT_SELECT     = 1;
    localparam int MS_REFERENCE_TRISTATE     = 2;
    localparam int MS_UNUSED   = 3;
    localparam int MS_AVG_OFF  = 4;
    localparam int MS_RATE     = 5;
    localparam int MS_SHUTDOWN_REQUEST     = 6;
    localparam int MS_DIODE2   = 7;

    // write mask for measurement_control: unused bit never stored
    localparam logic [7:0] MEAS_WMASK = 8'hF7;

    // conversion rates in conversions per second
    localparam int RATE_FAST_CPS = 32;
    localparam int RATE_SLOW_CPS = 4;

    // power-up settle time
    localparam int CLK_MHZ          = 100;
    localparam int POWERUP_US       = 10;
    localparam int POWERUP_CYCLES   = POWERUP_US * CLK_MHZ;

    // ahb transfer codes
    localparam logic [1:0] HTRANS_IDLE   = 2'b00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD    = 3'b010;

    typedef struct packed {
        logic       monitor_run;
        logic       limit_lock;
        logic       all_fans_full;
        logic       spinup_pulse_disable;
        logic       bus_timeout_disable;
        logic       supply_scale_5v;
        logic       offset_binary_format;
        logic       thermistor_type;
        logic       diode_current_select;
        logic       averaging_off;
        logic       conv_rate_slow;
        logic       shutdown_request;
        logic       second_diode_mode;
    } tmc_cfg_t;

    typedef struct packed {
        logic       use_programmed_limits;
        logic       fans_forced_full;
        logic       fans_forced_off;
        logic       analog_input_one_diode;
        logic       analog_input_two_diode;
        logic       smbus_timeout_enable;
    } tmc_ctl_t;

endpackage : tmc_pkg

// *** hw/tmc_powerup_timer.sv ***
// Purpose: holds the ready flag low until the power-up settle time has run out
// Assumes: synchronous active-high reset stands for power-on reset
// Notes:   count is a parameter so simulation can shorten it
`timescale 1ns/100ps
`default_nettype none
module tmc_powerup_timer #(
    parameter int CYCLES = tmc_pkg::POWERUP_CYCLES
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // status
    output logic      ready
);
    localparam int CW = (CYCLES < 2) ? 1 : $clog2(CYCLES + 1);

    // refused at elaboration: a zero count would wrap the 1-bit compare and raise ready after two cycles
    if (CYCLES < 1) begin : g_bad_cycles
        $error("tmc_powerup_timer: CYCLES must be at least 1");
    end

    logic [CW-1:0] cnt_q;
    logic          ready_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (!ready_q) begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ready_q <= 1'b0;
        end else if (cnt_q == CW'(CYCLES - 1)) begin
            ready_q <= 1'b1;
        end
    end

    assign ready = ready_q;
endmodule : tmc_powerup_timer
`default_nettype wire

// *** hw/tmc_config_regs.sv ***
// Purpose: two 8-bit configuration registers of a thermal monitor, on AHB-Lite
// Assumes: single word transfers, zero wait states, response always OKAY
// Notes:   lock is sticky until rst, which stands for a power cycle
//
// Functional notes
// - run bit selects programmed or default limits
// - clearing run leaves limit registers untouched
// - run bit read only once locked
// - lock is write once, freezes lockables
// - ready flag set after power-up completes
// - full-speed bit forces fans unless shutdown is set, never locked
// - spin-up pulse disable holds drive high
// - timeout disable bit, lockable
// - supply scale selects 5 V or 3.3 V
// - format bit selects binary or offset
// - second register read only once locked
// - thermistor type selects 100k or 10k
// - reference tristate floats reference output pin
// - bit 3 of second register reads zero
// - averaging-off bit disables measurement averaging
// - rate bit picks 32 or 4 per second
// - shutdown forces fan drives to zero
// - second diode mode overrides thermistor selects
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module tmc_config_regs #(
    parameter int POWERUP_CYCLES = tmc_pkg::POWERUP_CYCLES
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [11:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // configuration out to measurement and fan logic
    output tmc_pkg::tmc_cfg_t      cfg,
    output tmc_pkg::tmc_ctl_t      ctl,
    output logic                   conv_rate_applies,
    // fan drive path
    input  wire logic [7:0]        fan_drive_one_in,
    input  wire logic [7:0]        fan_drive_two_in,
    input  wire logic              spinup_active,
    input  wire logic              single_channel_mode,
    input  wire logic              thermistor_select_one,
    input  wire logic              thermistor_select_two,
    output logic [7:0]             fan_drive_one,
    output logic [7:0]             fan_drive_two,
    output logic                   spinup_use_tach_pulses,
    // reference output pin
    output logic                   reference_output_pin_oe
);
    if (POWERUP_CYCLES < 1) begin : g_bad_powerup
        $error("tmc_config_regs: POWERUP_CYCLES must be at least 1");
    end

    logic [7:0]  mon_q;
    logic [7:0]  meas_q;
    logic        wr_pend_q;
    logic [11:0] wr_addr_q;
    logic        ready;
    logic        addr_ok;
    logic        locked;
    logic        wr_mon;
    logic        wr_meas;
    logic [7:0]  mon_d;
    logic [7:0]  meas_d;
    logic [31:0] rdata_d;
    logic [7:0]  drive_one_d;
    logic [7:0]  drive_two_d;

    tmc_powerup_timer #(
        .CYCLES (POWERUP_CYCLES)
    ) u_pwr (
        .core_clk (core_clk),
        .rst      (rst),
        .ready    (ready)
    );

    // bus is never stalled, so every address phase is taken immediately
    assign addr_ok   = hsel && hready && (htrans == tmc_pkg::HTRANS_NONSEQ);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            wr_addr_q <= haddr;
        end
    end

    assign locked  = mon_q[tmc_pkg::MC_LOCK];
    assign wr_mon  = wr_pend_q && (wr_addr_q == tmc_pkg::MON_CTRL_ADDR);
    assign wr_meas = wr_pend_q && (wr_addr_q == tmc_pkg::MEAS_CTRL_ADDR);

    // lockable fields freeze once lock is set; full-speed and lock-set stay live
    always_comb begin
        mon_d = mon_q;
        if (wr_mon) begin
            if (!locked) begin
                mon_d[tmc_pkg::MC_RUN]      = hwdata[tmc_pkg::MC_RUN];
                mon_d[tmc_pkg::MC_SPIN_DIS] = hwdata[tmc_pkg::MC_SPIN_DIS];
                mon_d[tmc_pkg::MC_TO_DIS]   = hwdata[tmc_pkg::MC_TO_DIS];
                mon_d[tmc_pkg::MC_SUPPLY5]  = hwdata[tmc_pkg::MC_SUPPLY5];
                mon_d[tmc_pkg::MC_OFFBIN]   = hwdata[tmc_pkg::MC_OFFBIN];
            end
            // write once: only a 1 is taken, clear comes only from reset
            if (hwdata[tmc_pkg::MC_LOCK]) begin
                mon_d[tmc_pkg::MC_LOCK] = 1'b1;
            end
            mon_d[tmc_pkg::MC_FULL] = hwdata[tmc_pkg::MC_FULL];
        end
        mon_d[tmc_pkg::MC_READY] = 1'b0;
    end

    always_comb begin
        meas_d = meas_q;
        if (wr_meas && !locked) begin
            meas_d = hwdata[7:0] & tmc_pkg::MEAS_WMASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mon_q <= tmc_pkg::MON_CTRL_RST;
        end else begin
            mon_q <= mon_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            meas_q <= tmc_pkg::MEAS_CTRL_RST;
        end else begin
            meas_q <= meas_d;
        end
    end

    // read data registered for the data phase
    always_comb begin
        rdata_d = '0;
        unique case (haddr)
            tmc_pkg::MON_CTRL_ADDR: begin
                rdata_d[7:0] = mon_q;
                rdata_d[tmc_pkg::MC_READY] = ready;
            end
            tmc_pkg::MEAS_CTRL_ADDR: begin
                rdata_d[7:0] = meas_q;
            end
            tmc_pkg::STATUS_ADDR: begin
                rdata_d[7:0] = drive_one_d;
                rdata_d[15:8] = drive_two_d;
            end
            default: begin
                rdata_d = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hrdata <= '0;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rdata_d;
        end
    end

    // configuration fields out
    always_comb begin
        cfg.monitor_run          = mon_q[tmc_pkg::MC_RUN];
        cfg.limit_lock           = mon_q[tmc_pkg::MC_LOCK];
        cfg.all_fans_full        = mon_q[tmc_pkg::MC_FULL];
        cfg.spinup_pulse_disable = mon_q[tmc_pkg::MC_SPIN_DIS];
        cfg.bus_timeout_disable  = mon_q[tmc_pkg::MC_TO_DIS];
        cfg.supply_scale_5v      = mon_q[tmc_pkg::MC_SUPPLY5];
        cfg.offset_binary_format = mon_q[tmc_pkg::MC_OFFBIN];
        cfg.thermistor_type      = meas_q[tmc_pkg::MS_THERM10K];
        cfg.diode_current_select = meas_q[tmc_pkg::MS_DIODE_CURRENT_SELECT];
        cfg.averaging_off        = meas_q[tmc_pkg::MS_AVG_OFF];
        cfg.conv_rate_slow       = meas_q[tmc_pkg::MS_RATE];
        cfg.shutdown_request     = meas_q[tmc_pkg::MS_SHUTDOWN_REQUEST];
        cfg.second_diode_mode    = meas_q[tmc_pkg::MS_DIODE2];
    end

    // derived controls; limits themselves live elsewhere and are never touched here
    always_comb begin
        ctl.use_programmed_limits  = mon_q[tmc_pkg::MC_RUN] && ready;
        ctl.fans_forced_full       = mon_q[tmc_pkg::MC_FULL];
        ctl.fans_forced_off        = meas_q[tmc_pkg::MS_SHUTDOWN_REQUEST];
        ctl.analog_input_one_diode = meas_q[tmc_pkg::MS_DIODE2] || !thermistor_select_two;
        ctl.analog_input_two_diode = meas_q[tmc_pkg::MS_DIODE2] || !thermistor_select_one;
        ctl.smbus_timeout_enable   = !mon_q[tmc_pkg::MC_TO_DIS];
    end

    // rate bit only matters with averaging off and a single channel
    assign conv_rate_applies = meas_q[tmc_pkg::MS_AVG_OFF] && single_channel_mode;

    // shutdown beats full speed: fans off and drive readback zero
    always_comb begin
        if (meas_q[tmc_pkg::MS_SHUTDOWN_REQUEST]) begin
            drive_one_d = '0;
            drive_two_d = '0;
        end else if (mon_q[tmc_pkg::MC_FULL]) begin
            drive_one_d = 8'hFF;
            drive_two_d = 8'hFF;
        end else if (spinup_active && mon_q[tmc_pkg::MC_SPIN_DIS]) begin
            drive_one_d = 8'hFF;
            drive_two_d = 8'hFF;
        end else begin
            drive_one_d = fan_drive_one_in;
            drive_two_d = fan_drive_two_in;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fan_drive_one <= '0;
            fan_drive_two <= '0;
        end else begin
            fan_drive_one <= drive_one_d;
            fan_drive_two <= drive_two_d;
        end
    end

    assign spinup_use_tach_pulses  = !mon_q[tmc_pkg::MC_SPIN_DIS];
    assign reference_output_pin_oe = !meas_q[tmc_pkg::MS_REFERENCE_TRISTATE];

endmodule : tmc_config_regs
`default_nettype wire

// *** dv/tmc_config_regs_chk.sv ***
// Purpose: port-level checks of the configuration bank
// Assumes: sync active-high rst, one clock
// Notes:   bound to every tmc_config_regs instance
`timescale 1ns/100ps
`default_nettype none
module tmc_config_regs_chk #(
    parameter int POWERUP_CYCLES = tmc_pkg::POWERUP_CYCLES
) (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              rst,
    // watched signals
    input wire logic              single_channel_mode,
    input wire tmc_pkg::tmc_cfg_t cfg,
    input wire tmc_pkg::tmc_ctl_t ctl,
    input wire logic              conv_rate_applies,
    input wire logic [7:0]        fan_drive_one,
    input wire logic [7:0]        fan_drive_two,
    input wire logic              spinup_use_tach_pulses
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_RESET_DEFAULTS: assert property ($fell(rst) |-> cfg == 13'h1000)
        else $error("config fields not at defaults after reset");
    AST_LOCK_STICKY: assert property (cfg.limit_lock |=> cfg.limit_lock)
        else $error("lock cleared without reset");
    AST_RUN_FROZEN: assert property (cfg.limit_lock |=> $stable(cfg.monitor_run))
        else $error("run bit changed while locked");
    AST_MEAS_FROZEN: assert property (cfg.limit_lock |=> $stable(cfg[5:0]))
        else $error("measurement fields changed while locked");
    AST_SHUTDOWN_REQUEST_DRIVES: assert property (cfg.shutdown_request [*2]
        |-> fan_drive_one == 8'h00 && fan_drive_two == 8'h00)
        else $error("fan drive not zero in shutdown");
    AST_FULL_DRIVES: assert property ((cfg.all_fans_full && !cfg.shutdown_request) [*2]
        |-> fan_drive_one == 8'hFF && fan_drive_two == 8'hFF)
        else $error("fan drive not full speed");
    AST_DIODE2: assert property (cfg.second_diode_mode
        |-> ctl.analog_input_one_diode && ctl.analog_input_two_diode)
        else $error("analog inputs not in diode mode");
    AST_SPIN: assert property (spinup_use_tach_pulses != cfg.spinup_pulse_disable)
        else $error("spin-up tach select wrong");
    AST_TIMEOUT: assert property (ctl.smbus_timeout_enable != cfg.bus_timeout_disable)
        else $error("bus timeout enable wrong");
    AST_RATE: assert property (conv_rate_applies
        == (cfg.averaging_off && single_channel_mode))
        else $error("conversion rate qualifier wrong");

    cover property (cfg.limit_lock);
    cover property (cfg.shutdown_request);
    cover property (cfg.second_diode_mode && conv_rate_applies);
    cover property (cfg.spinup_pulse_disable && fan_drive_one == 8'hFF);
endmodule : tmc_config_regs_chk

bind tmc_config_regs tmc_config_regs_chk #(.POWERUP_CYCLES(POWERUP_CYCLES))
    i_tmc_config_regs_chk (
        .core_clk               (core_clk),
        .rst                    (rst),
        .single_channel_mode    (single_channel_mode),
        .cfg                    (cfg),
        .ctl                    (ctl),
        .conv_rate_applies      (conv_rate_applies),
        .fan_drive_one          (fan_drive_one),
        .fan_drive_two          (fan_drive_two),
        .spinup_use_tach_pulses (spinup_use_tach_pulses)
    );
`default_nettype wire

// *** dv/tmc_ahb_host.sv ***
// Purpose: ahb-lite host model issuing single word transfers
// Assumes: one slave whose hreadyout is fed back as hready
// Notes:   released write data is inverted so stale data never looks valid
`timescale 1ns/100ps
`default_nettype none
module tmc_ahb_host (
    // clock
    input  wire logic        core_clk,
    // ahb-lite master side
    output logic             hsel,
    output logic [11:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    initial begin
        hsel   = 1'b0;
        haddr  = 12'h000;
        htrans = tmc_pkg::HTRANS_IDLE;
        hwrite = 1'b0;
        hsize  = tmc_pkg::HSIZE_WORD;
        hwdata = 32'h0000_0000;
    end

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= tmc_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= tmc_pkg::HTRANS_IDLE;
        hwdata <= w ? d : ~hwdata;
        do @(posedge core_clk); while (hready !== 1'b1);
        q = hrdata;
        hwdata <= ~d;
    endtask : xfer
endmodule : tmc_ahb_host
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: register-level test of the configuration bank
// Assumes: short power-up count of 4 cycles
// Notes:   expectations follow the field layout, not design outputs
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [11:0] MON  = tmc_pkg::MON_CTRL_ADDR;
    localparam logic [11:0] MEAS = tmc_pkg::MEAS_CTRL_ADDR;
    localparam logic [11:0] DRV  = tmc_pkg::STATUS_ADDR;
    logic              core_clk = 1'b0;
    logic              rst      = 1'b1;
    logic              hsel, hwrite, hreadyout, hresp;
    logic              spinup_use_tach_pulses, reference_output_pin_oe;
    logic              conv_rate_applies;
    logic [11:0]       haddr;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic [31:0]       hwdata, hrdata;
    logic [7:0]        fan_drive_one, fan_drive_two;
    logic [7:0]        fan_drive_one_in = 8'h5A;
    logic [7:0]        fan_drive_two_in = 8'hA5;
    logic              spinup_active = 1'b0;
    logic              single_channel_mode = 1'b0;
    logic              thermistor_select_one = 1'b1;
    logic              thermistor_select_two = 1'b0;
    tmc_pkg::tmc_cfg_t cfg;
    tmc_pkg::tmc_ctl_t ctl;
    wire logic         hready;
    int                err_total = 0;
    int                total_checks = 0;

    assign hready = hreadyout;
    always #5 core_clk = ~core_clk;

    tmc_config_regs #(
        .POWERUP_CYCLES (4)
    ) i_tmc_config_regs (
        .core_clk                (core_clk),
        .rst                     (rst),
        .hsel                    (hsel),
        .haddr                   (haddr),
        .htrans                  (htrans),
        .hwrite                  (hwrite),
        .hsize                   (hsize),
        .hwdata                  (hwdata),
        .hready                  (hready),
        .hreadyout               (hreadyout),
        .hresp                   (hresp),
        .hrdata                  (hrdata),
        .cfg                     (cfg),
        .ctl                     (ctl),
        .conv_rate_applies       (conv_rate_applies),
        .fan_drive_one_in        (fan_drive_one_in),
        .fan_drive_two_in        (fan_drive_two_in),
        .spinup_active           (spinup_active),
        .single_channel_mode     (single_channel_mode),
        .thermistor_select_one   (thermistor_select_one),
        .thermistor_select_two   (thermistor_select_two),
        .fan_drive_one           (fan_drive_one),
        .fan_drive_two           (fan_drive_two),
        .spinup_use_tach_pulses  (spinup_use_tach_pulses),
        .reference_output_pin_oe (reference_output_pin_oe)
    );

    tmc_ahb_host i_tmc_ahb_host (
        .core_clk (core_clk),
        .hsel     (hsel),
        .haddr    (haddr),
        .htrans   (htrans),
        .hwrite   (hwrite),
        .hsize    (hsize),
        .hwdata   (hwdata),
        .hready   (hready),
        .hrdata   (hrdata)
    );

    task automatic report_and_stop();
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : cmp

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        i_tmc_ahb_host.xfer(1'b1, a, {24'h00_0000, d}, q);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        logic [31:0] q;
        i_tmc_ahb_host.xfer(1'b0, a, 32'h0000_0000, q);
        cmp(n, e, q);
    endtask : rd

    // generous bound: the sequence needs well under 300 cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        rd(MON, 32'h0000_0001, "mon_reset");
        rd(MEAS, 32'h0000_0000, "meas_reset");
        rd(MON, 32'h0000_0005, "mon_ready");
        wr(MEAS, 8'hFF);
        rd(MEAS, 32'h0000_00F7, "meas_unused_bit");
        rd(DRV, 32'h0000_0000, "drive_shutdown");
        cmp("ref_oe_off", 32'h0, {31'h0, reference_output_pin_oe});
        cmp("bus_resp", 32'h0000_0002, {30'h0, hreadyout, hresp});
        wr(MEAS, 8'h00);
        rd(DRV, 32'h0000_A55A, "drive_normal");
        cmp("ref_oe_on", 32'h1, {31'h0, reference_output_pin_oe});
        wr(MON, 8'h08);
        rd(MON, 32'h0000_000C, "mon_full");
        rd(DRV, 32'h0000_FFFF, "drive_full");
        cmp("limits_default", 32'h0, {31'h0, ctl.use_programmed_limits});
        // spin-up with pulse detection disabled holds the drives high
        wr(MON, 8'h10);
        spinup_active <= 1'b1;
        rd(DRV, 32'h0000_FFFF, "drive_spinup");
        cmp("tach_select", 32'h0, {31'h0, spinup_use_tach_pulses});
        spinup_active <= 1'b0;
        // limits belong to the engine outside this bank and are not set here
        wr(MON, 8'hC1);
        wr(MEAS, 8'h91);
        single_channel_mode <= 1'b1;
        thermistor_select_two <= 1'b1;
        @(negedge core_clk);
        cmp("cfg_fields", 32'h0000_10E9, {19'h0_0000, cfg});
        cmp("ctl_fields", 32'h0000_0027, {26'h000_0000, ctl});
        cmp("rate_applies", 32'h1, {31'h0, conv_rate_applies});
        rd(12'h010, 32'h0000_0000, "unmapped_read");
        wr(12'h010, 8'hFF);
        rd(MON, 32'h0000_00C5, "unmapped_write");
        wr(MON, 8'hE3);
        rd(MON, 32'h0000_00E7, "mon_locking");
        wr(MON, 8'h88);
        rd(MON, 32'h0000_00EF, "mon_locked");
        wr(MEAS, 8'h00);
        rd(MEAS, 32'h0000_0091, "meas_locked");
        wr(MON, 8'h80);
        rd(MON, 32'h0000_00E7, "full_after_lock");
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(MON, 32'h0000_0001, "mon_power_cycle");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
